// ===== bench/msic_host.sv
// Host model running one APB transfer per request
`timescale 1ns/1ps
module msic_host (
	input wire logic ref_clk_i,
	input wire logic req_i,
	input wire logic wr_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic pready_i,
	input wire logic pslverr_i,
	input wire logic [31:0] prdata_i,
	output logic psel_o = 1'h0,
	output logic penable_o = 1'h0,
	output logic pwrite_o = 1'h0,
	output logic [7:0] paddr_o = 8'h00,
	output logic [31:0] pwdata_o = 32'h0,
	output logic done_o = 1'h0,
	output logic err_o = 1'h0,
	output logic [31:0] rdata_o = 32'h0
);
	always @(posedge ref_clk_i) begin
		done_o <= 1'h0;
		if (psel_o && penable_o && pready_i) begin
			psel_o <= 1'h0;
			penable_o <= 1'h0;
			// Released address and data lines show no stale value
			paddr_o <= ~paddr_o;
			pwdata_o <= ~pwdata_o;
			rdata_o <= prdata_i;
			err_o <= pslverr_i;
			done_o <= 1'h1;
		end else if (psel_o) begin
			penable_o <= 1'h1;
		end else if (req_i && !done_o) begin
			psel_o <= 1'h1;
			pwrite_o <= wr_i;
			paddr_o <= addr_i;
			pwdata_o <= wdata_i;
		end
	end
endmodule : msic_host

// ===== bench/msic_regs_assertions.sv
// Port checks for the register bank
`timescale 1ns/1ps
module msic_regs_chk
	import msic_pkg::*;
#(
	parameter int SILO_DEPTH = 64,
	parameter int LINES = 16
) (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic tsr_load_i,
	input wire logic [15:0] tsr_data_i,
	input wire logic ric_load_i,
	input wire logic [15:0] ric_data_i,
	input wire logic rx_int_set_i,
	input wire logic go_o,
	input wire logic rx_silo_clear_o,
	input wire logic irq_a_o,
	input wire logic irq_b_o,
	input wire logic irq_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);
	////////////////////////////////////////
	sequence s_mclr;
		pready_o && pwrite_i && paddr_i == OFS_SCW && pwdata_i[15:0] == 16'h0800;
	endsequence
	sequence s_scw_wr;
		pready_o && pwrite_i && paddr_i == OFS_SCW && !pwdata_i[SCW_MCLR];
	endsequence
	property p_rdy;
		$rose(penable_i) && psel_i |-> !pready_o ##2 pready_o;
	endproperty
	a_rdy: assert property (p_rdy) else $error("late ready");
	property p_one;
		pready_o |=> !pready_o;
	endproperty
	a_one: assert property (p_one) else $error("long ready");
	property p_qual;
		pready_o |-> psel_i && penable_i;
	endproperty
	a_qual: assert property (p_qual) else $error("stray ready");
	property p_err;
		pslverr_o |-> pready_o;
	endproperty
	a_err: assert property (p_err) else $error("stray error");
	property p_unm;
		pready_o && paddr_i > OFS_IMK |-> pslverr_o;
	endproperty
	a_unm: assert property (p_unm) else $error("unmapped accepted");
	property p_scw_rd;
		pready_o && !pwrite_i && paddr_i == OFS_SCW |-> prdata_o[31:16] == 16'h0000 && !prdata_o[14];
	endproperty
	a_scw_rd: assert property (p_scw_rd) else $error("system word spare set");
	property p_lcw_rd;
		pready_o && !pwrite_i && paddr_i == OFS_LCW |-> prdata_o[31:6] == 26'h0 && prdata_o[3:2] == 2'h0;
	endproperty
	a_lcw_rd: assert property (p_lcw_rd) else $error("line word spare set");
	property p_go;
		s_scw_wr |=> go_o == $past(pwdata_i[SCW_GO]);
	endproperty
	a_go: assert property (p_go) else $error("go not written");
	property p_mc_pulse;
		s_mclr |-> ##[1:2] rx_silo_clear_o;
	endproperty
	a_mc_pulse: assert property (p_mc_pulse) else $error("no silo clear");
	property p_mc_one;
		rx_silo_clear_o |=> !rx_silo_clear_o;
	endproperty
	a_mc_one: assert property (p_mc_one) else $error("silo clear stuck");
	property p_mc_clr;
		s_mclr |-> ##4 !go_o && !irq_a_o && !irq_b_o;
	endproperty
	a_mc_clr: assert property (p_mc_clr) else $error("master clear missed");
	property p_rst;
		$rose(rstn_i) |-> !go_o && !irq_o && !irq_b_o && !pready_o;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule : msic_regs_chk

bind msic_regs msic_regs_chk #(.SILO_DEPTH(SILO_DEPTH), .LINES(LINES)) u_msic_regs_chk (.*);

// ===== bench/mux_status_interrupt_control_bench.sv
// Self-checking bench for the register bank
`timescale 1ns/1ps
module mux_status_interrupt_control_bench;
	import msic_pkg::*;
	typedef struct {logic w; logic [7:0] a; logic [15:0] d;} msic_row_t;
	logic ref_clk_i = 1'h0;
	logic rstn_i = 1'h0;
	logic ce_i = 1'h1;
	logic psel_i, penable_i, pwrite_i, pready_o, pslverr_o, done, err;
	logic go_o, rx_silo_clear_o, irq_a_o, irq_b_o, irq_o;
	logic [7:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, rdata;
	logic tsr_load_i = 1'h0;
	logic ric_load_i = 1'h0;
	logic rx_int_set_i = 1'h0;
	logic req = 1'h0;
	logic wr = 1'h0;
	logic [7:0] addr = 8'h00;
	logic [15:0] tsr_data_i = 16'h0000;
	logic [15:0] ric_data_i = 16'h0000;
	logic [31:0] wdata = 32'h0;
	int error_cnt = 0;
	int tests_run = 0;
	msic_row_t rows [16] = '{
		'{1'h0, OFS_SCW, 16'h0000},
		'{1'h1, OFS_SCW, 16'hF0B1},
		'{1'h0, OFS_SCW, 16'h3031},
		'{1'h1, OFS_SRS, 16'h0003},
		'{1'h1, OFS_SEC, 16'h0000},
		'{1'h1, OFS_SCW, 16'h3021},
		'{1'h0, OFS_LCW, 16'h0030},
		'{1'h1, OFS_SRS, 16'h0103},
		'{1'h0, OFS_LCW, 16'h0000},
		'{1'h1, OFS_SEC, 16'h0000},
		'{1'h0, OFS_LCW, 16'h0020},
		'{1'h1, OFS_SRS, 16'h0002},
		'{1'h0, OFS_LCW, 16'h0000},
		'{1'h1, OFS_SCW, 16'h3001},
		'{1'h1, OFS_IMK, 16'h0002},
		'{1'h0, OFS_IST, 16'h0000}
	};
	always #10 ref_clk_i = ~ref_clk_i;
	msic_regs #(.SILO_DEPTH(4)) u_msic_regs (.*);
	msic_host u_msic_host (.ref_clk_i(ref_clk_i), .req_i(req), .wr_i(wr), .addr_i(addr),
		.wdata_i(wdata), .pready_i(pready_o), .pslverr_i(pslverr_o), .prdata_i(prdata_o),
		.psel_o(psel_i), .penable_o(penable_i), .pwrite_o(pwrite_i), .paddr_o(paddr_i),
		.pwdata_o(pwdata_i), .done_o(done), .err_o(err), .rdata_o(rdata));
	////////////////////////////////////////
	task automatic give_verdict;
		$display("errors %0d checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : give_verdict
	task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] s);
		tests_run++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch %s exp %h got %h", nm, e, s);
		end
	endtask : chk16
	task automatic chk1(input string nm, input logic e, input logic s);
		chk16(nm, {15'h0000, e}, {15'h0000, s});
	endtask : chk1
	task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
		int n = 0;
		@(posedge ref_clk_i);
		req <= 1'h1;
		wr <= w;
		addr <= a;
		wdata <= {16'h0000, d};
		do begin
			@(negedge ref_clk_i);
			n++;
		end while (done !== 1'h1 && n < 40);
		if (n >= 40) begin
			error_cnt++;
			give_verdict();
		end
		@(posedge ref_clk_i);
		req <= 1'h0;
	endtask : xfer
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		xfer(1'h0, a, 16'h0000);
		chk16("rdata", e, rdata[15:0]);
	endtask : rd
	task automatic push(input logic [15:0] d);
		@(posedge ref_clk_i);
		tsr_load_i <= 1'h1;
		tsr_data_i <= d;
		@(posedge ref_clk_i);
		tsr_load_i <= 1'h0;
		repeat (3) @(negedge ref_clk_i);
	endtask : push
	////////////////////////////////////////
	initial begin
		repeat (16) @(posedge ref_clk_i);
		rstn_i <= 1'h1;
		foreach (rows[i]) begin
			if (rows[i].w) begin
				xfer(1'h1, rows[i].a, rows[i].d);
			end else begin
				rd(rows[i].a, rows[i].d);
			end
		end
		for (int i = 0; i < 4; i++) begin
			push(16'h0011 + 16'(i));
		end
		chk1("irq_b", 1'h1, irq_b_o);
		chk1("irq", 1'h1, irq_o);
		rd(OFS_SCW, 16'hB401);
		for (int i = 0; i < 4; i++) begin
			rd(OFS_TSR, 16'h0011 + 16'(i));
		end
		rd(OFS_SCW, 16'h3401);
		chk1("irq_b", 1'h1, irq_b_o);
		rd(OFS_IST, 16'h0003);
		push(16'h0000);
		chk1("irq", 1'h1, irq_o);
		rd(OFS_TSR, 16'h0000);
		xfer(1'h1, OFS_SCW, 16'h2601);
		rd(OFS_SCW, 16'h2601);
		chk1("irq_b", 1'h0, irq_b_o);
		xfer(1'h1, OFS_SCW, 16'hA601);
		rd(OFS_SCW, 16'hA601);
		chk1("irq_b", 1'h1, irq_b_o);
		xfer(1'h1, OFS_SCW, 16'h8601);
		xfer(1'h1, OFS_IMK, 16'h0000);
		push(16'h0021);
		chk1("irq_b", 1'h0, irq_b_o);
		chk1("irq", 1'h0, irq_o);
		rd(OFS_TSR, 16'h0021);
		rd(OFS_SCW, 16'h0601);
		xfer(1'h1, OFS_SCW, 16'h0440);
		@(posedge ref_clk_i);
		rx_int_set_i <= 1'h1;
		ric_load_i <= 1'h1;
		ric_data_i <= 16'hABCD;
		@(posedge ref_clk_i);
		rx_int_set_i <= 1'h0;
		ric_load_i <= 1'h0;
		repeat (3) @(negedge ref_clk_i);
		chk1("irq_a", 1'h1, irq_a_o);
		rd(OFS_SCW, 16'h04C0);
		rd(OFS_RIC, 16'hABCD);
		xfer(1'h1, OFS_SCW, 16'h0800);
		repeat (3) @(negedge ref_clk_i);
		rd(OFS_SCW, 16'h0000);
		rd(OFS_RIC, 16'h0000);
		chk1("irq_a", 1'h0, irq_a_o);
		xfer(1'h0, 8'h20, 16'h0000);
		chk1("pslverr", 1'h1, err);
		xfer(1'h1, OFS_SCW, 16'h3001);
		@(posedge ref_clk_i);
		rstn_i <= 1'h0;
		repeat (2) @(posedge ref_clk_i);
		rstn_i <= 1'h1;
		rd(OFS_SCW, 16'h0000);
		chk1("go", 1'h0, go_o);
		// Clock enable low must freeze the status flag
		@(posedge ref_clk_i);
		ce_i <= 1'h0;
		tsr_load_i <= 1'h1;
		@(posedge ref_clk_i);
		tsr_load_i <= 1'h0;
		ce_i <= 1'h1;
		rd(OFS_SCW, 16'h0000);
		give_verdict();
	end
endmodule : mux_status_interrupt_control_bench

// ===== hw/msic_pkg.sv
// Constants for the status and interrupt control register block
package msic_pkg;
	// APB byte addresses
	localparam logic [7:0] OFS_SCW = 8'h00;
	localparam logic [7:0] OFS_LCW = 8'h04;
	localparam logic [7:0] OFS_SRS = 8'h08;
	localparam logic [7:0] OFS_TSR = 8'h0C;
	localparam logic [7:0] OFS_RIC = 8'h10;
	localparam logic [7:0] OFS_SEC = 8'h14;
	localparam logic [7:0] OFS_IST = 8'h18;
	localparam logic [7:0] OFS_IMK = 8'h1C;

	// System control word fields
	localparam int SCW_GO = 0;
	localparam int SCW_XA_LO = 4;
	localparam int SCW_RXIE = 6;
	localparam int SCW_RXI = 7;
	localparam int SCW_RXDONE = 8;
	localparam int SCW_FWE = 9;
	localparam int SCW_OVF = 10;
	localparam int SCW_MCLR = 11;
	localparam int SCW_OVFIE = 12;
	localparam int SCW_TSIE = 13;
	localparam int SCW_TSI = 15;
	// Plain read/write bits: 0-6, 8, 9, 12, 13
	localparam logic [15:0] SCW_RW_MASK = 16'h337F;
	// Bits cleared by master clear
	localparam logic [15:0] SCW_MCLR_MASK = 16'hBECF;

	// Line control word fields
	localparam int LCW_XA_LO = 4;

	// Secondary register selector fields
	localparam int SRS_LINE_LO = 0;
	localparam int SRS_REG_LO = 8;
	localparam logic [3:0] SEC_CUR_ADDR = 4'h0;
	localparam logic [3:0] SEC_TBL_BASE = 4'h1;

	// Transfer status entry flag bit
	localparam int TSR_FLAG = 15;

	// Interrupt status bits
	localparam int IST_OVF = 0;
	localparam int IST_TSR = 1;
	localparam int IST_RXI = 2;
	localparam int IST_W = 3;

	// Reset values
	localparam logic [15:0] RST_16 = 16'h0000;
	localparam logic [31:0] RST_32 = 32'h0000_0000;
	localparam logic [1:0] RST_XA = 2'h0;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_WAIT = 2'b01,
		BUS_DONE = 2'b10
	} msic_bus_t;
endpackage : msic_pkg

// ===== hw/msic_regs.sv
// Status, interrupt and master clear register bank with APB slave
//
// Operation
// - Overflow flag set when status silo full
// - Overflow requests vector B only if enabled
// - Status flag requests vector B only if enabled
// - Master clear clears listed register bits
// - Master clear empties receive silo, self-clears
// - Status entry load sets status interrupt flag
// - Status flag writable only with write enable
// - Reset clears overflow, enables, status flag
// - Line word shows selected extended address bits
// - Selector picks line for secondary accesses
// - Extended address bits feed secondary loads
`timescale 1ns/1ps
module msic_regs
	import msic_pkg::*;
#(
	parameter int SILO_DEPTH = 64,
	parameter int LINES = 16
) (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic tsr_load_i,
	input wire logic [15:0] tsr_data_i,
	input wire logic ric_load_i,
	input wire logic [15:0] ric_data_i,
	input wire logic rx_int_set_i,
	output logic go_o,
	output logic rx_silo_clear_o,
	output logic irq_a_o,
	output logic irq_b_o,
	output logic irq_o
);
	////////////////////////////////////////////////////////////////////////////
	// Declarations
	localparam int SEC_N = LINES * 2;
	localparam int SEC_AW = $clog2(SEC_N);

	msic_bus_t bus_q;
	logic [15:0] scw_rw_q;
	logic rxi_q;
	logic ovf_q;
	logic tsi_q;
	logic mclr_q;
	logic [15:0] srs_q;
	logic [15:0] ric_q;
	logic tsr_flag_clr_q;
	logic [1:0] xa_mem [SEC_N];
	logic [IST_W-1:0] ist_q;
	logic [IST_W-1:0] imk_q;
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic irq_a_q;
	logic irq_b_q;
	logic irq_q;
	logic rdy_q;
	logic ovf_prev_q;
	logic wr;
	logic rd;
	logic [15:0] wd;
	logic [15:0] tsr_head;
	logic silo_full;
	logic silo_empty;
	logic tsr_pop;
	logic hit;
	logic [15:0] rdata;
	logic [IST_W-1:0] ist_set;

	// Index of the secondary extended address slot chosen by the selector
	function automatic logic [SEC_AW-1:0] sec_idx(input logic [15:0] secondary_register_selector);
		logic [3:0] line;
		logic [3:0] kind;
		line = secondary_register_selector[SRS_LINE_LO +: 4];
		kind = secondary_register_selector[SRS_REG_LO +: 4];
		sec_idx = SEC_AW'({line, (kind == SEC_TBL_BASE)});
	endfunction : sec_idx
	function automatic logic is_sec_addr(input logic [15:0] secondary_register_selector);
		is_sec_addr = (secondary_register_selector[SRS_REG_LO +: 4] == SEC_CUR_ADDR) ||
			(secondary_register_selector[SRS_REG_LO +: 4] == SEC_TBL_BASE);
	endfunction : is_sec_addr

	////////////////////////////////////////////////////////////////////////////
	// APB handshake: two wait cycles so read data comes from a flop
	assign wr = (bus_q == BUS_DONE) && psel_i && penable_i && pwrite_i;
	assign rd = (bus_q == BUS_DONE) && psel_i && penable_i && !pwrite_i;
	assign wd = pwdata_i[15:0];

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bus_q <= BUS_IDLE;
			rdy_q <= 1'b0;
		end else if (ce_i) begin
			rdy_q <= (bus_q == BUS_WAIT);
			case (bus_q)
				BUS_IDLE: begin
					if (psel_i && penable_i) begin
						bus_q <= BUS_WAIT;
					end
				end
				BUS_WAIT: bus_q <= BUS_DONE;
				BUS_DONE: bus_q <= BUS_IDLE;
				default: bus_q <= BUS_IDLE;
			endcase
		end
	end
	always_comb begin
		hit = 1'b1;
		rdata = RST_16;
		case (paddr_i)
			OFS_SCW: begin
				rdata = scw_rw_q;
				rdata[SCW_RXI] = rxi_q;
				rdata[SCW_OVF] = ovf_q;
				rdata[SCW_MCLR] = mclr_q;
				rdata[SCW_TSI] = tsi_q;
			end
			OFS_LCW: rdata[LCW_XA_LO +: 2] = xa_mem[sec_idx(srs_q)];
			OFS_SRS: rdata = srs_q;
			OFS_TSR: begin
				rdata = tsr_head;
				if (tsr_flag_clr_q) begin
					rdata[TSR_FLAG] = 1'b0;
				end
			end
			OFS_RIC: rdata = ric_q;
			OFS_IST: rdata[IST_W-1:0] = ist_q;
			OFS_IMK: rdata[IST_W-1:0] = imk_q;
			OFS_SEC: rdata = RST_16;
			default: hit = 1'b0;
		endcase
	end
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			prdata_q <= RST_32;
			pslverr_q <= 1'b0;
		end else if (ce_i) begin
			if (bus_q == BUS_WAIT) begin
				prdata_q <= pwrite_i ? RST_32 : {16'h0000, rdata};
				pslverr_q <= !hit;
			end else if (bus_q == BUS_DONE) begin
				pslverr_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// System control word
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			scw_rw_q <= RST_16;
		end else if (ce_i) begin
			if (mclr_q) begin
				scw_rw_q <= scw_rw_q & ~SCW_MCLR_MASK;
			end else if (wr && paddr_i == OFS_SCW) begin
				scw_rw_q <= wd & SCW_RW_MASK;
			end
		end
	end

	// Master clear pulse, gone one cycle after the write
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mclr_q <= 1'b0;
		end else if (ce_i) begin
			mclr_q <= wr && paddr_i == OFS_SCW && wd[SCW_MCLR];
		end
	end

	// Receiver interrupt flag; service complete clears it
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rxi_q <= 1'b0;
		end else if (ce_i) begin
			if (rx_int_set_i) begin
				rxi_q <= 1'b1;
			end else if (mclr_q) begin
				rxi_q <= 1'b0;
			end else if (wr && paddr_i == OFS_SCW) begin
				if (wd[SCW_RXDONE]) begin
					rxi_q <= 1'b0;
				end else if (scw_rw_q[SCW_FWE]) begin
					rxi_q <= wd[SCW_RXI];
				end
			end
		end
	end

	// Overflow flag set by a full silo and held; set wins over clears
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ovf_q <= 1'b0;
		end else if (ce_i) begin
			if (silo_full) begin
				ovf_q <= 1'b1;
			end else if (mclr_q) begin
				ovf_q <= 1'b0;
			end else if (wr && paddr_i == OFS_SCW) begin
				ovf_q <= wd[SCW_OVF];
			end
		end
	end

	// Transfer status interrupt flag
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tsi_q <= 1'b0;
		end else if (ce_i) begin
			if (tsr_load_i) begin
				tsi_q <= 1'b1;
			end else if (mclr_q) begin
				tsi_q <= 1'b0;
			end else if (rd && paddr_i == OFS_TSR) begin
				tsi_q <= 1'b0;
			end else if (wr && paddr_i == OFS_SCW && scw_rw_q[SCW_FWE]) begin
				tsi_q <= wd[SCW_TSI];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Transfer status silo
	assign tsr_pop = rd && paddr_i == OFS_TSR;
	msic_silo #(
		.WIDTH(16),
		.DEPTH(SILO_DEPTH)
	) u_silo (
		.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i),
		.ce_i(ce_i),
		.push_i(tsr_load_i),
		.data_i(tsr_data_i),
		.pop_i(tsr_pop),
		.head_o(tsr_head),
		.full_o(silo_full),
		.empty_o(silo_empty)
	);

	// Master clear hides the flag bit of the shown entry until the next pop
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tsr_flag_clr_q <= 1'b0;
		end else if (ce_i) begin
			if (mclr_q) begin
				tsr_flag_clr_q <= 1'b1;
			end else if (tsr_pop || silo_empty) begin
				tsr_flag_clr_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Receive character, selector and secondary extended address
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ric_q <= RST_16;
		end else if (ce_i) begin
			if (ric_load_i) begin
				ric_q <= ric_data_i;
			end else if (mclr_q) begin
				ric_q <= RST_16;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			srs_q <= RST_16;
		end else if (ce_i && wr && paddr_i == OFS_SRS) begin
			srs_q <= wd;
		end
	end
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			xa_mem <= '{default: RST_XA};
		end else if (ce_i && wr && paddr_i == OFS_SEC && is_sec_addr(srs_q)) begin
			xa_mem[sec_idx(srs_q)] <= scw_rw_q[SCW_XA_LO +: 2];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupts
	assign ist_set = {rx_int_set_i, tsr_load_i, ovf_q && !ovf_prev_q};

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ist_q <= '0;
			imk_q <= '0;
			ovf_prev_q <= 1'b0;
		end else if (ce_i) begin
			ovf_prev_q <= ovf_q;
			if (rd && paddr_i == OFS_IST) begin
				ist_q <= (ist_q & ~prdata_q[IST_W-1:0]) | ist_set; // Clear only what was read
			end else begin
				ist_q <= ist_q | ist_set;
			end
			if (wr && paddr_i == OFS_IMK) begin
				imk_q <= wd[IST_W-1:0];
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_a_q <= 1'b0;
			irq_b_q <= 1'b0;
			irq_q <= 1'b0;
		end else if (ce_i) begin
			irq_a_q <= rxi_q && scw_rw_q[SCW_RXIE];
			irq_b_q <= (ovf_q && scw_rw_q[SCW_OVFIE]) ||
				(tsi_q && scw_rw_q[SCW_TSIE]);
			irq_q <= |(ist_q & imk_q);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign prdata_o = prdata_q;
	assign pready_o = rdy_q;
	assign pslverr_o = pslverr_q;
	assign go_o = scw_rw_q[SCW_GO];
	assign rx_silo_clear_o = mclr_q;
	assign irq_a_o = irq_a_q;
	assign irq_b_o = irq_b_q;
	assign irq_o = irq_q;
endmodule : msic_regs

// ===== hw/msic_silo.sv
// First-in first-out silo for transfer status entries
`timescale 1ns/1ps
module msic_silo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 64
) (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic push_i,
	input wire logic [WIDTH-1:0] data_i,
	input wire logic pop_i,
	output logic [WIDTH-1:0] head_o,
	output logic full_o,
	output logic empty_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wptr_q;
	logic [AW-1:0] rptr_q;
	logic [AW:0] cnt_q;
	logic do_push;
	logic do_pop;

	assign full_o = (cnt_q == (AW+1)'(DEPTH));
	assign empty_o = (cnt_q == '0);
	assign head_o = mem[rptr_q];
	assign do_push = push_i && !full_o;
	assign do_pop = pop_i && !empty_o;

	always_ff @(posedge ref_clk_i) begin
		if (ce_i && do_push) begin
			mem[wptr_q] <= data_i;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wptr_q <= '0;
			rptr_q <= '0;
			cnt_q <= '0;
		end else if (ce_i) begin
			if (do_push) begin
				wptr_q <= wptr_q + 1'b1;
			end
			if (do_pop) begin
				rptr_q <= rptr_q + 1'b1;
			end
			if (do_push && !do_pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (do_pop && !do_push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule : msic_silo
